// ### shared/acs_ltr_regs.svh
// Register offsets, field positions and reset values for the ACS/LTR block
`ifndef ACS_LTR_REGS_SVH
`define ACS_LTR_REGS_SVH

// Byte offsets of the four words
`define OFS_ACC_CAP_CTRL     12'h224
`define OFS_EGRESS_VEC       12'h228
`define OFS_LAT_CAP_HDR      12'h230
`define OFS_MAX_LATENCY      12'h234

// Capability advertisement, bits 6:0 all ones
`define ACC_CAP_BITS         7'h7F
`define ACC_CAP_LSB          0
// Egress vector size field and its value
`define EGR_SIZE_LSB         8
`define EGR_SIZE_VAL         8'h08
// Enable bits 22:16
`define ACC_EN_LSB           16
`define ACC_EN_W             7
`define ACC_EN_RST           7'h00
// Egress control vector
`define EGR_VEC_W            8
`define EGR_VEC_RST          8'h00

// Latency capability header fields
`define LAT_CAP_ID           16'h0018
`define LAT_CAP_VER          4'h1
`define LAT_CAP_NEXT         12'h240

// Latency fields: snoop 12:0, no-snoop 28:16
`define LAT_FIELD_W          13
`define LAT_FIELD_RST        13'h0000
`define LAT_SNOOP_LSB        0
`define LAT_NOSNOOP_LSB      16

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ### shared/acs_ltr_pkg.sv
// Types shared by the ACS/LTR register block
package acs_ltr_pkg;

    // Which face of the switch this configuration space belongs to
    typedef enum logic {
        PORT_UPSTREAM,
        PORT_DOWNSTREAM
    } port_role_e;

    // Word address within the configuration window
    typedef logic [11:0] cfg_addr_t;

endpackage

// ### shared/reg_access_if.sv
// Decoded register access strobes between bus slave and register file
`timescale 1ns/1ps
interface reg_access_if;
    logic        wr_en;      // One-cycle write strobe
    logic [11:0] wr_addr;    // Byte address of write
    logic [31:0] wr_data;    // Write data
    logic [3:0]  wr_strb;    // Byte enables
    logic [11:0] rd_addr;    // Byte address of read
    logic [31:0] rd_data;    // Combinational read data
    logic        rd_hit;     // Read address maps to a register
    logic        wr_hit;     // Write address maps to a register

    modport bus (output wr_en, output wr_addr, output wr_data,
                 output wr_strb, output rd_addr,
                 input rd_data, input rd_hit, input wr_hit);
    modport regs (input wr_en, input wr_addr, input wr_data,
                  input wr_strb, input rd_addr,
                  output rd_data, output rd_hit, output wr_hit);
endinterface

// ### src/acs_ltr_regfile.sv
// Register storage and read mux for the ACS and LTR capabilities
`timescale 1ns/1ps
`include "acs_ltr_regs.svh"
module acs_ltr_regfile
    import acs_ltr_pkg::*;
(
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Port role, fixed per instance
    input  wire port_role_e                role,
    // Access from the bus slave
    reg_access_if.regs                     acc,
    // Register contents toward the datapath
    output logic [`ACC_EN_W-1:0]           acs_en_r,
    output logic [`EGR_VEC_W-1:0]          egress_vec_r,
    output logic [`LAT_FIELD_W-1:0]        snoop_lat_r,
    output logic [`LAT_FIELD_W-1:0]        nosnoop_lat_r
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode, role gated

    wire is_down = (role == PORT_DOWNSTREAM);     // ACS lives downstream
    wire rd_cap  = is_down && acc.rd_addr == `OFS_ACC_CAP_CTRL;
    wire rd_egr  = is_down && acc.rd_addr == `OFS_EGRESS_VEC;
    wire rd_hdr  = !is_down && acc.rd_addr == `OFS_LAT_CAP_HDR;
    wire rd_lat  = !is_down && acc.rd_addr == `OFS_MAX_LATENCY;
    wire wr_cap  = is_down && acc.wr_addr == `OFS_ACC_CAP_CTRL;
    wire wr_egr  = is_down && acc.wr_addr == `OFS_EGRESS_VEC;
    wire wr_hdr  = !is_down && acc.wr_addr == `OFS_LAT_CAP_HDR;
    wire wr_lat  = !is_down && acc.wr_addr == `OFS_MAX_LATENCY;

    assign acc.rd_hit = rd_cap | rd_egr | rd_hdr | rd_lat;
    // Header write is accepted and dropped: read-only, not an error
    assign acc.wr_hit = wr_cap | wr_egr | wr_hdr | wr_lat;

    // Byte-masked merges; reserved positions never stored
    wire [31:0] wmask = {{8{acc.wr_strb[3]}}, {8{acc.wr_strb[2]}},
                         {8{acc.wr_strb[1]}}, {8{acc.wr_strb[0]}}};
    wire [31:0] cap_old = {9'h000, acs_en_r, 16'h0000};
    wire [31:0] cap_mrg = (acc.wr_data & wmask) | (cap_old & ~wmask);
    wire [31:0] lat_old = {3'h0, nosnoop_lat_r, 3'h0, snoop_lat_r};
    wire [31:0] lat_mrg = (acc.wr_data & wmask) | (lat_old & ~wmask);

    wire [`ACC_EN_W-1:0]    acs_en_nxt  =
        cap_mrg[`ACC_EN_LSB +: `ACC_EN_W];
    wire [`EGR_VEC_W-1:0]   egress_nxt  = acc.wr_strb[0] ?
        acc.wr_data[`EGR_VEC_W-1:0] : egress_vec_r;
    wire [`LAT_FIELD_W-1:0] snoop_nxt   =
        lat_mrg[`LAT_SNOOP_LSB +: `LAT_FIELD_W];
    wire [`LAT_FIELD_W-1:0] nosnoop_nxt =
        lat_mrg[`LAT_NOSNOOP_LSB +: `LAT_FIELD_W];

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Enables, bits 16..22 map to acs_en_r[0..6]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acs_en_r <= `ACC_EN_RST;
        end else if (acc.wr_en && wr_cap) begin
            acs_en_r <= acs_en_nxt;
        end
    end

    // Egress control vector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            egress_vec_r <= `EGR_VEC_RST;
        end else if (acc.wr_en && wr_egr) begin
            egress_vec_r <= egress_nxt;
        end
    end

    // Snoop and no-snoop latency limits share one word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snoop_lat_r   <= `LAT_FIELD_RST;
            nosnoop_lat_r <= `LAT_FIELD_RST;
        end else if (acc.wr_en && wr_lat) begin
            snoop_lat_r   <= snoop_nxt;
            nosnoop_lat_r <= nosnoop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unselected and reserved bits read zero

    wire [31:0] cap_word = {9'h000, acs_en_r, `EGR_SIZE_VAL,
                            1'b0, `ACC_CAP_BITS};
    wire [31:0] hdr_word = {`LAT_CAP_NEXT, `LAT_CAP_VER,
                            `LAT_CAP_ID};
    assign acc.rd_data = rd_cap ? cap_word :
                         rd_egr ? {24'h000000, egress_vec_r} :
                         rd_hdr ? hdr_word :
                         rd_lat ? lat_old : 32'h00000000;

endmodule

// ### src/acs_ltr_config_registers.sv
// AXI4-Lite slave wrapping the ACS and LTR capability registers
//
// Notes on behaviour
// - Capability bits 6:0 read-only, read one
// - Egress vector size field reads 08h
// - Source validation enable, RW, resets zero
// - Translation blocking enable, RW, resets zero
// - Request redirect enable, RW, resets zero
// - Completion redirect enable, RW, resets zero
// - Upstream forwarding enable, RW, resets zero
// - Egress vector acts only when enabled
// - Direct translated peer enable, RW, resets zero
// - Egress vector RW, resets zero, blocks ports
// - ACS registers exist on downstream ports only
// - LTR header upstream only, 0018h/1h/240h
// - Snoop latency value/scale RW, reset zero
// - No-snoop latency value/scale RW, reset zero
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acs_ltr_regs.svh"
module acs_ltr_config_registers
    import acs_ltr_pkg::*;
#(
    parameter port_role_e ROLE = PORT_DOWNSTREAM
)(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Effective controls toward the forwarding logic
    output logic              src_valid_on_r,
    output logic              xlat_block_on_r,
    output logic              req_redirect_on_r,
    output logic              cpl_redirect_on_r,
    output logic              up_forward_on_r,
    output logic              direct_xlat_on_r,
    output logic [7:0]        egress_block_r,
    output logic [12:0]       snoop_lat_limit_r,
    output logic [12:0]       nosnoop_lat_limit_r
);

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture

    reg_access_if acc ();

    logic        aw_have_r;      // Address held
    logic        w_have_r;       // Data held
    logic [11:0] aw_addr_r;      // Captured write address
    logic [31:0] w_data_r;       // Captured write data
    logic [3:0]  w_strb_r;       // Captured byte enables

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    // Both halves present and no response pending: commit this cycle
    wire wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;

    // Address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Ready while the holding slot is empty and no write response is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid
                             && !wr_go;
            s_axi_wready  <= !w_have_r && !w_take && !s_axi_bvalid
                             && !wr_go;
        end
    end

    assign acc.wr_en   = wr_go;
    assign acc.wr_addr = aw_addr_r;
    assign acc.wr_data = w_data_r;
    assign acc.wr_strb = w_strb_r;

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= acc.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: address taken, data one cycle later

    wire ar_take = s_axi_arvalid && s_axi_arready;
    assign acc.rd_addr = {s_axi_araddr[11:2], 2'b00};

    // Ready only when no read data is waiting, so one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
        end
    end

    // Read data sampled at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= acc.rd_data;
            s_axi_rresp  <= acc.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [6:0]  acs_en;         // Enable bits 22:16 as stored
    logic [7:0]  egress_vec;     // Stored egress control vector
    logic [12:0] snoop_lat;      // Stored snoop limit
    logic [12:0] nosnoop_lat;    // Stored no-snoop limit

    acs_ltr_regfile u_regs (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .role          (ROLE),
        .acc           (acc),
        .acs_en_r      (acs_en),
        .egress_vec_r  (egress_vec),
        .snoop_lat_r   (snoop_lat),
        .nosnoop_lat_r (nosnoop_lat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Datapath controls, registered so every output leaves a flop

    // The vector is masked here so the forwarding logic need not know
    // about the egress enable
    wire [7:0] egress_eff = acs_en[5] ? egress_vec : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_valid_on_r      <= 1'b0;
            xlat_block_on_r     <= 1'b0;
            req_redirect_on_r   <= 1'b0;
            cpl_redirect_on_r   <= 1'b0;
            up_forward_on_r     <= 1'b0;
            direct_xlat_on_r    <= 1'b0;
            egress_block_r      <= 8'h00;
            snoop_lat_limit_r   <= 13'h0000;
            nosnoop_lat_limit_r <= 13'h0000;
        end else begin
            src_valid_on_r      <= acs_en[0];
            xlat_block_on_r     <= acs_en[1];
            req_redirect_on_r   <= acs_en[2];
            cpl_redirect_on_r   <= acs_en[3];
            up_forward_on_r     <= acs_en[4];
            direct_xlat_on_r    <= acs_en[6];
            egress_block_r      <= egress_eff;
            snoop_lat_limit_r   <= snoop_lat;
            nosnoop_lat_limit_r <= nosnoop_lat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Write checks on the control and limit outputs look two edges on: one for the store, one for the
    // output flop. No second write can commit inside that span, as the
    // pending response holds the next one off.

    chk_egress_gated: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !acs_en[5] |=> egress_block_r == 8'h00)
        else $error("egress vector active while egress enable is off");

    chk_cap_read_ones: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take && ROLE == PORT_DOWNSTREAM
        && acc.rd_addr == `OFS_ACC_CAP_CTRL
        |=> s_axi_rdata[15:0] == 16'h087F && s_axi_rdata[31:23] == 9'h0)
        else $error("capability word fixed bits wrong");

    chk_hdr_value: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take && ROLE == PORT_UPSTREAM
        && acc.rd_addr == `OFS_LAT_CAP_HDR
        |=> s_axi_rdata == 32'h24010018 && s_axi_rresp == `RESP_OKAY)
        else $error("latency header value wrong");

    chk_hdr_hidden_dn: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take && ROLE == PORT_DOWNSTREAM
        && acc.rd_addr == `OFS_LAT_CAP_HDR
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("latency header visible on downstream port");

    chk_acs_hidden_up: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take && ROLE == PORT_UPSTREAM
        && acc.rd_addr == `OFS_EGRESS_VEC
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("egress vector visible on upstream port");

    // A hidden register must refuse the write and keep its zero
    chk_wr_hidden_up: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go && ROLE == PORT_UPSTREAM
        && aw_addr_r == `OFS_ACC_CAP_CTRL
        |=> s_axi_bresp == `RESP_SLVERR && acs_en == 7'h00)
        else $error("capability write taken on upstream port");

    chk_en_write: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go && ROLE == PORT_DOWNSTREAM && w_strb_r[2]
        && aw_addr_r == `OFS_ACC_CAP_CTRL
        |=> ##1 src_valid_on_r == $past(w_data_r[16], 2)
        && xlat_block_on_r == $past(w_data_r[17], 2))
        else $error("enable write did not reach control");

    chk_en_redirect: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go && ROLE == PORT_DOWNSTREAM && w_strb_r[2]
        && aw_addr_r == `OFS_ACC_CAP_CTRL
        |=> ##1 req_redirect_on_r == $past(w_data_r[18], 2)
        && cpl_redirect_on_r == $past(w_data_r[19], 2)
        && up_forward_on_r == $past(w_data_r[20], 2)
        && direct_xlat_on_r == $past(w_data_r[22], 2))
        else $error("redirect or forwarding enable lost");

    chk_egress_store: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go && ROLE == PORT_DOWNSTREAM && w_strb_r[0]
        && aw_addr_r == `OFS_EGRESS_VEC
        |=> egress_vec == $past(w_data_r[7:0]))
        else $error("egress vector write lost");

    chk_lat_write: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go && ROLE == PORT_UPSTREAM && (&w_strb_r)
        && aw_addr_r == `OFS_MAX_LATENCY
        |=> ##1 snoop_lat_limit_r == $past(w_data_r[12:0], 2)
        && nosnoop_lat_limit_r == $past(w_data_r[28:16], 2))
        else $error("latency write did not reach limits");

    // Not disabled by reset: this one watches the reset itself
    chk_reset_clear: assert property (@(posedge aclk)
        !aresetn |=> acs_en == 7'h00 && egress_vec == 8'h00
        && snoop_lat == 13'h0000 && nosnoop_lat == 13'h0000)
        else $error("register not cleared by reset");

    chk_reserved_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_axi_rvalid && ROLE == PORT_UPSTREAM
        |-> s_axi_rdata[31:29] == 3'h0 || s_axi_rdata[31:20] == 12'h240)
        else $error("reserved latency bits nonzero");

    chk_bresp_timing: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");

endmodule

// ### verification/test_acs_ltr_config_registers.sv
// Self-checking bench for the ACS/LTR register block, both port roles
`timescale 1ns/1ps
module test_acs_ltr_config_registers
    import acs_ltr_pkg::*;
;
    // Clock, reset and shared bus inputs
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    // Outputs per instance: index 0 downstream, 1 upstream
    logic        awready [2], wready [2], bvalid [2], arready [2], rvalid [2];
    logic [1:0]  bresp   [2], rresp  [2];
    logic [31:0] rdata   [2];
    logic [5:0]  ctl     [2];
    logic [7:0]  egress  [2];
    logic [12:0] snoop   [2], nosnoop [2];
    // Bench model of the writable contents
    logic [31:0] m224, m228, m234;
    logic [31:0] rng = 32'h0000B036;   // Seed, 45110 in decimal
    int          err_count = 0;
    int          checked = 0;
    logic [11:0] addrs [7] = '{12'h220, 12'h224, 12'h228, 12'h22C,
                               12'h230, 12'h234, 12'h238};

    // 100 ns period
    always #50 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    // Both roles share one bus so every access hits both maps at once
    for (genvar i = 0; i < 2; i++) begin : g_port
        acs_ltr_config_registers #(
            .ROLE(i == 0 ? PORT_DOWNSTREAM : PORT_UPSTREAM)
        ) acs_ltr_config_registers_inst (
            .aclk(aclk), .aresetn(aresetn),
            .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
            .s_axi_awready(awready[i]),
            .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
            .s_axi_wready(wready[i]),
            .s_axi_bresp(bresp[i]), .s_axi_bvalid(bvalid[i]),
            .s_axi_bready(bready),
            .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
            .s_axi_arready(arready[i]),
            .s_axi_rdata(rdata[i]), .s_axi_rresp(rresp[i]),
            .s_axi_rvalid(rvalid[i]), .s_axi_rready(rready),
            .src_valid_on_r(ctl[i][0]), .xlat_block_on_r(ctl[i][1]),
            .req_redirect_on_r(ctl[i][2]), .cpl_redirect_on_r(ctl[i][3]),
            .up_forward_on_r(ctl[i][4]), .direct_xlat_on_r(ctl[i][5]),
            .egress_block_r(egress[i]),
            .snoop_lat_limit_r(snoop[i]), .nosnoop_lat_limit_r(nosnoop[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Repeatable xorshift source
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Address decodes per role; hidden registers must error
    function automatic logic hit(int up, logic [11:0] a);
        if (up == 0) return (a == 12'h224) || (a == 12'h228);
        return (a == 12'h230) || (a == 12'h234);
    endfunction

    // Expected read word: fixed capability bits merged with stored fields
    function automatic logic [31:0] exp_word(int up, logic [11:0] a);
        if (!hit(up, a)) return 32'h00000000;
        if (a == 12'h224) return m224 | 32'h0000087F;
        if (a == 12'h228) return m228;
        if (a == 12'h230) return 32'h24010018;
        return m234;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One comparison, counted
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write: both halves offered together, each dropped once taken
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
        logic [31:0] bm;
        int          n;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awvalid && awready[0]) awvalid <= 1'b0;
            if (wvalid && wready[0]) wvalid <= 1'b0;
            if (bvalid[0] === 1'b1) break;
        end
        if (n == 60) chk("write_timeout", 32'h0, 32'h1);
        chk("bresp_dn", hit(0, a) ? 2'h0 : 2'h2, bresp[0]);
        chk("bresp_up", hit(1, a) ? 2'h0 : 2'h2, bresp[1]);
        bready <= 1'b0;
        // Only writable bits survive; reserved and read-only bits drop
        if (a == 12'h224) m224 = ((m224 & ~bm) | (d & bm)) & 32'h007F0000;
        if (a == 12'h228) m228 = ((m228 & ~bm) | (d & bm)) & 32'h000000FF;
        if (a == 12'h234) m234 = ((m234 & ~bm) | (d & bm)) & 32'h1FFF1FFF;
    endtask

    // Read one word and compare both roles' answers
    task automatic rd(logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arvalid && arready[0]) arvalid <= 1'b0;
            if (rvalid[0] === 1'b1) break;
        end
        if (n == 60) chk("read_timeout", 32'h0, 32'h1);
        chk("rdata_dn", exp_word(0, a), rdata[0]);
        chk("rdata_up", exp_word(1, a), rdata[1]);
        chk("rresp_dn", hit(0, a) ? 2'h0 : 2'h2, rresp[0]);
        chk("rresp_up", hit(1, a) ? 2'h0 : 2'h2, rresp[1]);
        rready <= 1'b0;
    endtask

    // Sweep the map and the control outputs against the model
    task automatic check_all();
        foreach (addrs[k]) rd(addrs[k]);
        #1;
        chk("ctl_lo_dn", m224[20:16], ctl[0][4:0]);
        chk("ctl_hi_dn", m224[22], ctl[0][5]);
        chk("ctl_up", 6'h00, ctl[1]);
        chk("egress_dn", m228[7:0] & {8{m224[21]}}, egress[0]);
        chk("egress_up", 8'h00, egress[1]);
        chk("snoop_up", m234[12:0], snoop[1]);
        chk("nosnoop_up", m234[28:16], nosnoop[1]);
        chk("lat_dn", 26'h0, {snoop[0], nosnoop[0]});
    endtask

    // Reset for ten cycles and clear the model
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        m224 = 32'h0;
        m228 = 32'h0;
        m234 = 32'h0;
    endtask

    // Verdict; both runs end here
    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] r;
        do_reset();
        check_all();
        $display("test reset_values done");
        // All ones everywhere: read-only and reserved bits must not move
        foreach (addrs[k]) wr(addrs[k], 32'hFFFFFFFF, 4'hF);
        check_all();
        $display("test all_ones done");
        // Egress vector only reaches the output while bit 21 is set
        wr(12'h228, 32'h000000A5, 4'hF);
        wr(12'h224, 32'h005F0000, 4'hF);
        check_all();
        wr(12'h224, 32'h00200000, 4'h4);
        check_all();
        $display("test egress_gate done");
        // Random addresses, data and byte enables, including no strobe
        repeat (30) begin
            r = xs();
            wr(addrs[r[7:0] % 7], xs(), r[11:8]);
            check_all();
        end
        $display("test random_access done");
        // Second reset in mid-run returns every field to zero
        wr(12'h234, 32'h1FFF1FFF, 4'hF);
        wr(12'h224, 32'h007F0000, 4'hF);
        do_reset();
        check_all();
        $display("test mid_reset done");
        summarize();
    end

    // Watchdog: the tests need well under 20000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end
endmodule
